// *** cca_pkg.sv ***
// constants, bus carrier and state record for the second counter array's register block
// assumes one system clock and the special-function-register strobes of the core
// Function
// - counter low byte at 0xF9, page 0x10
// - counter high byte at 0xFA, same page
// - high read returns snapshot loaded by low read
// - module capture low bytes at their addresses
// - module capture high bytes at their addresses
// - low address reaches reload low when selected
// - high address reaches reload high when selected
// - capture low write clears comparator enable
// - capture high write sets comparator enable
// - comparator enable gates the module's comparator
// - enabled match sets capture compare flag
package cca_pkg;
   localparam int NUM_MOD = 6;
   localparam logic [7:0] SFR_PAGE = 8'h10;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'hF9;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'hFA;
   // index 0 is module 6, index 5 is module 11
   localparam logic [NUM_MOD-1:0][7:0] ADDR_CAP_LOW = {8'hCE, 8'hFD, 8'hED, 8'hEB, 8'hE9, 8'hFB};
   localparam logic [NUM_MOD-1:0][7:0] ADDR_CAP_HIGH = {8'hCF, 8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC};
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // one special-function-register access, strobes last a single cycle
   typedef struct packed {
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cca_sfr_req_s;

   // whole state of the block
   typedef struct packed {
      logic [15:0] count;
      logic [7:0] snap;
      logic [NUM_MOD-1:0][15:0] cap;
      logic [NUM_MOD-1:0][15:0] reload;
      logic [NUM_MOD-1:0] cmp_en;
      logic [NUM_MOD-1:0] flag;
      logic [NUM_MOD-1:0] match;
      logic [7:0] rdata;
      logic rvalid;
   } cca_state_s;
endpackage

// *** cca_regs.sv ***
// counter, snapshot, capture/compare and auto-reload byte registers of the second counter array
// assumes counting ticks, mode bits and flag clears come from logic on i_clk_sys
`timescale 1ns/1ns
module cca_regs
   import cca_pkg::*;
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // register access
   input wire cca_sfr_req_s i_sfr,
   output logic o_sfr_hit,
   output logic o_sfr_rvalid,
   output logic [7:0] o_sfr_rdata,
   // counter and mode control
   input wire logic i_count_tick,
   input wire logic i_auto_reload_select,
   input wire logic [NUM_MOD-1:0] i_match_function_enable,
   input wire logic [NUM_MOD-1:0] i_mode_wr,
   input wire logic [NUM_MOD-1:0] i_mode_comparator_enable,
   input wire logic [NUM_MOD-1:0] i_flag_clear,
   // module state
   output logic [15:0] o_count,
   output logic [NUM_MOD-1:0][15:0] o_capture,
   output logic [NUM_MOD-1:0][15:0] o_reload,
   output logic [NUM_MOD-1:0] o_comparator_function_enable,
   output logic [NUM_MOD-1:0] o_capture_compare_flag
);
   cca_state_s st_q;
   cca_state_s st_d;
   logic page_ok;
   logic cnt_lo_hit;
   logic cnt_hi_hit;
   logic [NUM_MOD-1:0] lo_hit;
   logic [NUM_MOD-1:0] hi_hit;
   logic [NUM_MOD-1:0] match_now;

   // address decode, only page 0x10 answers
   assign page_ok = (i_sfr.page == SFR_PAGE);
   assign cnt_lo_hit = page_ok && (i_sfr.addr == ADDR_COUNT_LOW);
   assign cnt_hi_hit = page_ok && (i_sfr.addr == ADDR_COUNT_HIGH);

   // per-module decode and compare
   for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
      assign lo_hit[g] = page_ok && (i_sfr.addr == ADDR_CAP_LOW[g]);
      assign hi_hit[g] = page_ok && (i_sfr.addr == ADDR_CAP_HIGH[g]);
      // comparator only looks when both enables are on
      assign match_now[g] = (st_q.count == st_q.cap[g]) && i_match_function_enable[g] && st_q.cmp_en[g];
   end

   // hit is combinational, read valid and data are registered
   assign o_sfr_hit = cnt_lo_hit || cnt_hi_hit || (|lo_hit) || (|hi_hit);
   assign o_sfr_rvalid = st_q.rvalid;
   assign o_sfr_rdata = st_q.rdata;
   assign o_count = st_q.count;
   assign o_capture = st_q.cap;
   assign o_reload = st_q.reload;
   assign o_comparator_function_enable = st_q.cmp_en;
   assign o_capture_compare_flag = st_q.flag;

   // next-state logic for the whole block
   always_comb begin
      logic [7:0] rd_mux;
      rd_mux = RESET_BYTE;
      st_d = st_q;
      st_d.rvalid = 1'b0;
      // a byte write wins over a tick in the same cycle for its own byte; the other byte keeps the ticked value
      if (i_count_tick) begin
         st_d.count = st_q.count + 16'h0001;
      end
      if (i_sfr.wr && cnt_lo_hit) begin
         st_d.count[7:0] = i_sfr.wdata;
      end
      if (i_sfr.wr && cnt_hi_hit) begin
         st_d.count[15:8] = i_sfr.wdata;
      end
      // read mux; the high byte comes from the snapshot so a low-then-high pair is coherent
      if (cnt_lo_hit) begin
         rd_mux = st_q.count[7:0];
      end else if (cnt_hi_hit) begin
         rd_mux = st_q.snap;
      end
      if (i_sfr.rd && cnt_lo_hit) begin
         st_d.snap = st_q.count[15:8];
      end
      for (int k = 0; k < NUM_MOD; k++) begin
         if (lo_hit[k]) begin
            rd_mux = i_auto_reload_select ? st_q.reload[k][7:0] : st_q.cap[k][7:0];
         end else if (hi_hit[k]) begin
            rd_mux = i_auto_reload_select ? st_q.reload[k][15:8] : st_q.cap[k][15:8];
         end
         // mode register write first, capture byte writes override it
         if (i_mode_wr[k]) begin
            st_d.cmp_en[k] = i_mode_comparator_enable[k];
         end
         if (i_sfr.wr && lo_hit[k]) begin
            if (i_auto_reload_select) begin
               st_d.reload[k][7:0] = i_sfr.wdata;
            end else begin
               st_d.cap[k][7:0] = i_sfr.wdata;
               st_d.cmp_en[k] = 1'b0;
            end
         end
         if (i_sfr.wr && hi_hit[k]) begin
            if (i_auto_reload_select) begin
               st_d.reload[k][15:8] = i_sfr.wdata;
            end else begin
               st_d.cap[k][15:8] = i_sfr.wdata;
               st_d.cmp_en[k] = 1'b1;
            end
         end
         // flag set on the first cycle of a match; set wins over clear
         if (i_flag_clear[k]) begin
            st_d.flag[k] = 1'b0;
         end
         if (match_now[k] && !st_q.match[k]) begin
            st_d.flag[k] = 1'b1;
         end
         st_d.match[k] = match_now[k];
      end
      // unmapped reads give no valid and keep old data
      if (i_sfr.rd && o_sfr_hit) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = rd_mux;
      end
      if (i_rst) begin
         st_d = '0;
      end
   end

   // single state register
   always_ff @(posedge i_clk_sys) begin
      st_q <= st_d;
   end

   // checks
   // hazards the checks below guard:
   // - a low-byte read must capture the upper byte in the same cycle, or a tick
   //   between the two reads would tear the 16-bit value seen by software
   // - reload and capture share addresses, so a write aimed at one must never
   //   leak into the other, nor touch the comparator enable when it is a reload write
   // - reads are free of side effects apart from the snapshot load
   // - a held match must not re-set the flag after software has cleared it
   // limitation: the bus carries no wait states, so every answer is exactly one cycle late
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence s_low_read;
      i_sfr.rd && cnt_lo_hit;
   endsequence
   sequence s_high_read;
      i_sfr.rd && cnt_hi_hit;
   endsequence

   a_low_read_data: assert property (s_low_read |=> st_q.rvalid && st_q.rdata == $past(st_q.count[7:0]))
      else $error("counter low byte read wrong");
   a_high_write_count: assert property (i_sfr.wr && cnt_hi_hit |=> st_q.count[15:8] == $past(i_sfr.wdata))
      else $error("counter high byte write lost");
   a_snapshot_coherent: assert property (s_low_read ##1 (!(i_sfr.rd && cnt_lo_hit))[*1] ##0 s_high_read
      |=> st_q.rdata == $past(st_q.count[15:8], 2))
      else $error("high byte read not from snapshot");
   a_snapshot_hold: assert property (!(i_sfr.rd && cnt_lo_hit) |=> $stable(st_q.snap))
      else $error("snapshot changed without low read");
   a_reset_clear: assert property (@(posedge i_clk_sys) disable iff (1'b0) i_rst |=> st_q.count == 16'h0000
      && st_q.cap == '0 && st_q.reload == '0 && st_q.cmp_en == '0)
      else $error("registers not cleared by reset");
   a_unmapped_quiet: assert property (i_sfr.rd && !o_sfr_hit |=> !st_q.rvalid)
      else $error("valid on unmapped read");

   // low read, one idle cycle, then high read: high gives the upper byte of the low-read cycle
   a_snapshot_pair: assert property (s_low_read ##1 !(i_sfr.rd && cnt_lo_hit) ##1 s_high_read
      |=> st_q.rdata == $past(st_q.count[15:8], 3))
      else $error("snapshot pair not coherent");
   // low read loads the snapshot with the live upper byte
   a_snapshot_load: assert property (s_low_read |=> st_q.snap == $past(st_q.count[15:8]))
      else $error("snapshot not loaded by low read");
   // high read answers from the snapshot register
   a_high_read_snap: assert property (s_high_read |=> st_q.rvalid && st_q.rdata == $past(st_q.snap))
      else $error("high read not from snapshot");
   // low byte write lands in the counter
   a_low_write_count: assert property (i_sfr.wr && cnt_lo_hit |=> st_q.count[7:0] == $past(i_sfr.wdata))
      else $error("counter low byte write lost");
   // a tick without a counter write adds one
   a_count_tick: assert property (i_count_tick && !(i_sfr.wr && (cnt_lo_hit || cnt_hi_hit))
      |=> st_q.count == $past(st_q.count) + 16'h0001)
      else $error("counter did not advance");
   // no tick and no counter write keeps the count
   a_count_hold: assert property (!i_count_tick && !(i_sfr.wr && (cnt_lo_hit || cnt_hi_hit))
      |=> $stable(st_q.count))
      else $error("counter changed without cause");
   // every mapped read is answered one cycle later
   a_read_answered: assert property (i_sfr.rd && o_sfr_hit |=> st_q.rvalid)
      else $error("mapped read not answered");
   // no read strobe, no answer
   a_no_read_quiet: assert property (!i_sfr.rd |=> !st_q.rvalid)
      else $error("answer without read");
   // read data holds until the next mapped read
   a_rdata_hold: assert property (!(i_sfr.rd && o_sfr_hit) |=> $stable(st_q.rdata))
      else $error("read data changed without read");
   // a write to another page touches no byte register
   a_page_gate: assert property (i_sfr.wr && i_sfr.page != SFR_PAGE
      |=> $stable(st_q.cap) && $stable(st_q.reload))
      else $error("write on other page took effect");
   // an unmapped write leaves all byte registers alone
   a_unmapped_write_quiet: assert property (i_sfr.wr && !o_sfr_hit && !i_count_tick
      |=> $stable(st_q.count) && $stable(st_q.cap) && $stable(st_q.reload))
      else $error("unmapped write took effect");
   // reset also clears flags, snapshot and the read port
   a_reset_flags: assert property (@(posedge i_clk_sys) disable iff (1'b0) i_rst
      |=> st_q.flag == '0 && st_q.snap == 8'h00 && !st_q.rvalid && st_q.rdata == 8'h00)
      else $error("flags or read port not cleared by reset");

   for (genvar a = 0; a < NUM_MOD; a++) begin : g_chk
      a_cap_low_write: assert property (i_sfr.wr && lo_hit[a] && !i_auto_reload_select
         |=> st_q.cap[a][7:0] == $past(i_sfr.wdata) && !st_q.cmp_en[a])
         else $error("capture low write did not clear enable");
      a_cap_high_write: assert property (i_sfr.wr && hi_hit[a] && !i_auto_reload_select
         |=> st_q.cap[a][15:8] == $past(i_sfr.wdata) && st_q.cmp_en[a])
         else $error("capture high write did not set enable");
      a_reload_select: assert property (i_sfr.wr && (lo_hit[a] || hi_hit[a]) && i_auto_reload_select
         |=> $stable(st_q.cap[a]) && $stable(st_q.cmp_en[a]) || $past(i_mode_wr[a]))
         else $error("reload write reached capture register");
      a_reload_read_high: assert property (i_sfr.rd && hi_hit[a] && i_auto_reload_select
         |=> st_q.rdata == $past(st_q.reload[a][15:8]))
         else $error("reload high byte read wrong");
      a_flag_on_match: assert property (match_now[a] && !st_q.match[a] |=> st_q.flag[a])
         else $error("match did not set flag");
      a_no_flag_disabled: assert property (!st_q.cmp_en[a] && !st_q.flag[a] |=> !st_q.flag[a])
         else $error("flag set with comparator disabled");

      // reload low write with select high
      a_reload_low_write: assert property (i_sfr.wr && lo_hit[a] && i_auto_reload_select
         |=> st_q.reload[a][7:0] == $past(i_sfr.wdata))
         else $error("reload low byte write lost");
      // reload high write with select high
      a_reload_high_write: assert property (i_sfr.wr && hi_hit[a] && i_auto_reload_select
         |=> st_q.reload[a][15:8] == $past(i_sfr.wdata))
         else $error("reload high byte write lost");
      // capture low read with select low
      a_cap_low_read: assert property (i_sfr.rd && lo_hit[a] && !i_auto_reload_select
         |=> st_q.rdata == $past(st_q.cap[a][7:0]))
         else $error("capture low byte read wrong");
      // capture high read with select low
      a_cap_high_read: assert property (i_sfr.rd && hi_hit[a] && !i_auto_reload_select
         |=> st_q.rdata == $past(st_q.cap[a][15:8]))
         else $error("capture high byte read wrong");
      // reload low read with select high
      a_reload_read_low: assert property (i_sfr.rd && lo_hit[a] && i_auto_reload_select
         |=> st_q.rdata == $past(st_q.reload[a][7:0]))
         else $error("reload low byte read wrong");
      // reads never move the comparator enable
      a_read_keeps_enable: assert property (!i_sfr.wr && !i_mode_wr[a] |=> $stable(st_q.cmp_en[a]))
         else $error("enable changed without write");
      // mode write loads the enable unless a capture byte write overrides it
      a_mode_load: assert property (i_mode_wr[a] && !(i_sfr.wr && (lo_hit[a] || hi_hit[a]) && !i_auto_reload_select)
         |=> st_q.cmp_en[a] == $past(i_mode_comparator_enable[a]))
         else $error("mode write did not load enable");
      // capture holds unless a capture byte write reaches it
      a_cap_hold: assert property (!(i_sfr.wr && (lo_hit[a] || hi_hit[a]) && !i_auto_reload_select)
         |=> $stable(st_q.cap[a]))
         else $error("capture changed without write");
      // reload holds unless a reload byte write reaches it
      a_reload_hold: assert property (!(i_sfr.wr && (lo_hit[a] || hi_hit[a]) && i_auto_reload_select)
         |=> $stable(st_q.reload[a]))
         else $error("reload changed without write");
      // flag is sticky until cleared
      a_flag_sticky: assert property (st_q.flag[a] && !i_flag_clear[a] |=> st_q.flag[a])
         else $error("flag dropped without clear");
      // clear without a new match drops the flag
      a_flag_clear: assert property (i_flag_clear[a] && !(match_now[a] && !st_q.match[a]) |=> !st_q.flag[a])
         else $error("flag not cleared");
      // match function off: no flag
      a_no_match_enable: assert property (!i_match_function_enable[a] && !st_q.flag[a] |=> !st_q.flag[a])
         else $error("flag set with match function off");
      // match history follows the compare one cycle late
      a_match_track: assert property (1'b1 |=> st_q.match[a] == $past(match_now[a]))
         else $error("match history wrong");
   end
endmodule

// *** cca_regs_bench.sv ***
// self-checking bench for the second counter array's register block
// assumes cca_pkg and cca_regs are compiled ahead of it
`timescale 1ns/1ns
module cca_regs_bench;
   import cca_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic tick = 1'b0;
   logic sel = 1'b0;
   cca_sfr_req_s sfr = '0;
   logic [5:0] men = '0;
   logic [5:0] fclr = '0;
   logic [5:0] mwr = '0;
   logic [5:0] mce = '0;
   logic hit, rv;
   logic [7:0] rd, hv, lv;
   logic [15:0] cnt;
   logic [5:0][15:0] cap, rel, cv;
   logic [5:0] cen, flg;
   logic [7:0] exp_q[$];
   int err_total = 0;
   int compares = 0;
   // mode loads come from the bench: their register lives outside this block
   cca_regs dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sfr(sfr), .o_sfr_hit(hit), .o_sfr_rvalid(rv),
      .o_sfr_rdata(rd), .i_count_tick(tick), .i_auto_reload_select(sel), .i_match_function_enable(men),
      .i_mode_wr(mwr), .i_mode_comparator_enable(mce), .i_flag_clear(fclr), .o_count(cnt),
      .o_capture(cap), .o_reload(rel), .o_comparator_function_enable(cen), .o_capture_compare_flag(flg));
   initial forever #4 i_clk_sys = ~i_clk_sys;
   task automatic chk(input logic [15:0] got, input logic [15:0] want, input string m);
      compares++;
      if (got !== want) begin
         err_total++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task automatic give_verdict;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one strobe cycle, then idle; returns at the taking edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      sfr <= '{page: SFR_PAGE, addr: a, wdata: d, wr: w, rd: !w};
      @(posedge i_clk_sys);
      sfr <= '0;
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acc(1'b0, a, 8'h00);
   endtask
   // read answers come back in request order, so the oldest note matches
   always @(posedge i_clk_sys) begin
      if (rv === 1'b1) begin
         if (exp_q.size() == 0) chk(16'h1, 16'h0, "unexpected read answer");
         else chk({8'h00, rd}, {8'h00, exp_q.pop_front()}, "read data");
      end
   end
   initial begin
      #20000;
      err_total++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h4995));
      repeat (12) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rd_exp(ADDR_COUNT_LOW, 8'h00);
      rd_exp(ADDR_COUNT_HIGH, 8'h00);
      // capture pass first, then reload pass with select high
      for (int s = 0; s < 2; s++) begin
         sel <= s[0];
         for (int m = 0; m < NUM_MOD; m++) begin
            hv = 8'($urandom);
            lv = 8'($urandom);
            rd_exp(ADDR_CAP_LOW[m], 8'h00);
            acc(1'b1, ADDR_CAP_HIGH[m], hv);
            @(negedge i_clk_sys);
            chk({15'h0, cen[m]}, {15'h0, s == 0}, "enable after high write");
            acc(1'b1, ADDR_CAP_LOW[m], lv);
            @(negedge i_clk_sys);
            chk({15'h0, cen[m]}, 16'h0, "enable after low write");
            if (s == 0) cv[m] = {hv, lv};
            chk(cap[m], cv[m], "capture value");
            chk(rel[m], (s == 0) ? 16'h0 : {hv, lv}, "reload value");
            rd_exp(ADDR_CAP_LOW[m], lv);
            rd_exp(ADDR_CAP_HIGH[m], hv);
         end
      end
      sel <= 1'b0;
      acc(1'b0, 8'h00, 8'h00);
      acc(1'b1, 8'hF8, 8'h5A);
      // decode is strobe-independent; another page never answers
      @(posedge i_clk_sys);
      sfr <= '{page: SFR_PAGE, addr: ADDR_CAP_LOW[3], wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      @(negedge i_clk_sys);
      chk({15'h0, hit}, 16'h1, "decode hit");
      @(posedge i_clk_sys);
      sfr <= '{page: 8'h0F, addr: ADDR_CAP_LOW[3], wdata: 8'h3C, wr: 1'b1, rd: 1'b0};
      @(negedge i_clk_sys);
      chk({15'h0, hit}, 16'h0, "other page hit");
      @(posedge i_clk_sys);
      sfr <= '0;
      @(negedge i_clk_sys);
      chk(cap[3], cv[3], "other page write");
      acc(1'b1, ADDR_COUNT_HIGH, 8'hA5);
      acc(1'b1, ADDR_COUNT_LOW, 8'hFF);
      rd_exp(ADDR_COUNT_HIGH, 8'h00);
      rd_exp(ADDR_COUNT_LOW, 8'hFF);
      tick <= 1'b1;
      @(posedge i_clk_sys);
      tick <= 1'b0;
      @(negedge i_clk_sys);
      chk(cnt, 16'hA600, "counter after tick");
      rd_exp(ADDR_COUNT_HIGH, 8'hA5);
      rd_exp(ADDR_COUNT_LOW, 8'h00);
      rd_exp(ADDR_COUNT_HIGH, 8'hA6);
      // counter equals module 6 value while its comparator is off
      men <= 6'h3F;
      acc(1'b1, ADDR_COUNT_HIGH, cv[0][15:8]);
      acc(1'b1, ADDR_COUNT_LOW, cv[0][7:0]);
      repeat (3) @(negedge i_clk_sys);
      chk({10'h0, flg}, 16'h0, "flag with comparator off");
      acc(1'b1, ADDR_CAP_HIGH[0], cv[0][15:8]);
      repeat (2) @(negedge i_clk_sys);
      chk({10'h0, flg}, 16'h1, "flag on match");
      fclr <= 6'h01;
      @(posedge i_clk_sys);
      fclr <= 6'h00;
      repeat (2) @(negedge i_clk_sys);
      chk({10'h0, flg}, 16'h0, "flag after clear");
      // mode write loads the comparator enable of module 7
      @(posedge i_clk_sys);
      mce <= 6'h02;
      mwr <= 6'h02;
      @(posedge i_clk_sys);
      mwr <= 6'h00;
      @(negedge i_clk_sys);
      chk({10'h0, cen}, 16'h0003, "enable after mode write");
      repeat (4) @(posedge i_clk_sys);
      chk(16'(exp_q.size()), 16'h0, "missing read answers");
      give_verdict();
   end
endmodule
